// File: ssm_pkg.sv
// Package of register map, field positions and timing constants for the sync serial master
package ssm_pkg;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] ADDR_TX_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_RX_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_BAUD_DIV  = 8'h08;
  localparam logic [7:0] ADDR_TX_HOLD   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS    = 8'h10;

  // ************************************************************
  // Transmit control fields
  // ************************************************************
  localparam int TXC_CLOCK_SOURCE_MASTER = 7;
  localparam int TXC_NINE_BIT_SELECT     = 6;
  localparam int TXC_TRANSMIT_ENABLE     = 5;
  localparam int TXC_CLOCKED_MODE        = 4;
  localparam int TXC_HIGH_SPEED_BAUD     = 2;
  localparam int TXC_SHIFT_EMPTY         = 1;
  localparam int TXC_NINTH_BIT           = 0;
  localparam logic [7:0] TXC_WRITE_MASK  = 8'hf5;
  localparam logic [7:0] TXC_RESET       = 8'h00;

  // ************************************************************
  // Receive control fields
  // ************************************************************
  localparam int RXC_SERIAL_PORT_ENABLE  = 7;
  localparam int RXC_SINGLE_RECEIVE      = 5;
  localparam int RXC_CONTINUOUS_RECEIVE  = 4;
  localparam logic [7:0] RXC_WRITE_MASK  = 8'hb0;
  localparam logic [7:0] RXC_RESET       = 8'h00;

  // ************************************************************
  // Status fields
  // ************************************************************
  localparam int STS_HOLD_FULL  = 0;
  localparam int STS_BUSY       = 1;
  localparam int STS_MASTER_TX  = 2;

  // ************************************************************
  // Data widths and timing
  // ************************************************************
  localparam int          DATA_BITS       = 8;
  localparam int          DIV_WIDTH       = 8;
  localparam logic [7:0]  DIV_RESET       = 8'h00;
  localparam int          PHASES_PER_BAUD = 4;
  localparam int          CLK_FREQ_MHZ    = 200;
  localparam logic        SHIFT_CLK_IDLE  = 1'b0;

  typedef enum logic [1:0] {
    SSM_IDLE,
    SSM_LEAD,
    SSM_TRAIL
  } ssm_state_t;

endpackage : ssm_pkg

// File: ssm_baud_gen.sv
// Baud tick generator: one tick per half shift clock
`timescale 1ns/1ps
module ssm_baud_gen #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Control
  input  wire logic             run_in,
  input  wire logic [DIV_W-1:0] divisor_in,
  // Tick
  output logic                  tick_out
);

  // Half shift period is two oscillator quarters of (n+1), so 2(n+1) clocks
  logic [DIV_W+1:0] count;
  logic [DIV_W+1:0] limit;

  assign limit = {1'b0, divisor_in, 1'b1};

  always_ff @(posedge clk_in) begin
    if (rst_in || !run_in) begin
      count    <= '0;
      tick_out <= 1'b0;
    end else if (count >= limit) begin
      count    <= '0;
      tick_out <= 1'b1;
    end else begin
      count    <= count + 1'b1;
      tick_out <= 1'b0;
    end
  end

endmodule : ssm_baud_gen

// File: ssm_tx_shift.sv
// Transmit shift register with bit counter, hidden from software
`timescale 1ns/1ps
module ssm_tx_shift #(
  parameter int WIDTH = 9
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Load
  input  wire logic             load_in,
  input  wire logic [WIDTH-1:0] data_in,
  input  wire logic [3:0]       nbits_in,
  // Shift
  input  wire logic             shift_in,
  // State
  output logic                  bit_out,
  output logic                  busy_out,
  output logic                  last_out
);

  logic [WIDTH-1:0] shreg;
  logic [3:0]       left;

  assign busy_out = (left != 4'h0);
  assign last_out = (left == 4'h1);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shreg   <= '0;
      left    <= 4'h0;
      bit_out <= 1'b0;
    end else if (load_in) begin
      shreg   <= data_in >> 1;
      bit_out <= data_in[0];
      left    <= nbits_in;
    end else if (shift_in && busy_out) begin
      shreg   <= shreg >> 1;
      bit_out <= shreg[0];
      left    <= left - 4'h1;
    end
  end

endmodule : ssm_tx_shift

// File: ssm_sync_master_tx.sv
// Top of the synchronous master transmit path with APB register slave
//
// Notes on behaviour
// - Clocked mode bit set selects synchronous operation instead of async framing.
// - Clocked mode plus clock source master makes the unit generate shift clock.
// - Master transmits only while both receive enables are clear.
// - Nothing runs unless the serial port enable bit is set.
// - Data line never driven while configured to receive; half duplex.
// - Only data bits are sent, no start or stop bits.
// - Master drives the shift clock onto the clock pin.
// - Clock pin driver enabled whenever synchronous master transmit or receive.
// - Data changes on leading clock edge, valid at trailing edge.
// - Exactly one shift clock cycle per data bit.
// - In master transmit, drive data pin and enable both pin drivers.
// - Writing the transmit holding register starts a transmission.
// - New character waits in holding register while shift register busy.
// - First character or empty shift register loads holding register at once.
// - Shifting starts right after the load into the shift register.
// - Each bit stable on data pin from one leading edge to the next.
// - Shift register is not visible to software.
// - Shift clock equals oscillator over four times divisor plus one.
// - Transmit enable bit places the unit in transmit mode.
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
module ssm_sync_master_tx #(
  parameter int DIV_W = ssm_pkg::DIV_WIDTH
) (
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        SYS_RST_IN,
  // APB slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Clock pin
  input  wire logic        CLOCK_PIN_IN,
  output logic             CLOCK_PIN_OUT,
  output logic             CLOCK_PIN_OE_OUT,
  // Data pin
  input  wire logic        DATA_PIN_IN,
  output logic             DATA_PIN_OUT,
  output logic             DATA_PIN_OE_OUT
);

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0]       transmit_control_reg;
  logic [7:0]       receive_control_reg;
  logic [DIV_W-1:0] baud_divisor;
  logic [8:0]       transmit_holding_reg;
  logic             hold_full;

  logic apb_write;
  logic apb_read;
  logic addr_ok;
  logic wr_tx_ctrl;
  logic wr_rx_ctrl;
  logic wr_baud;
  logic wr_hold;

  assign apb_write   = PSEL_IN && PENABLE_IN && PWRITE_IN;
  // Read data fetched in setup, so it stands through the access phase
  assign apb_read    = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
  assign PREADY_OUT  = 1'b1;
  assign addr_ok     = (PADDR_IN == ssm_pkg::ADDR_TX_CTRL) ||
                       (PADDR_IN == ssm_pkg::ADDR_RX_CTRL) ||
                       (PADDR_IN == ssm_pkg::ADDR_BAUD_DIV) ||
                       (PADDR_IN == ssm_pkg::ADDR_TX_HOLD) ||
                       (PADDR_IN == ssm_pkg::ADDR_STATUS);
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !addr_ok;

  // ************************************************************
  // Write strobes
  // ************************************************************
  assign wr_tx_ctrl = apb_write && (PADDR_IN == ssm_pkg::ADDR_TX_CTRL);
  assign wr_rx_ctrl = apb_write && (PADDR_IN == ssm_pkg::ADDR_RX_CTRL);
  assign wr_baud    = apb_write && (PADDR_IN == ssm_pkg::ADDR_BAUD_DIV);
  assign wr_hold    = apb_write && (PADDR_IN == ssm_pkg::ADDR_TX_HOLD);

  // ************************************************************
  // Mode decode
  // ************************************************************
  logic port_on;
  logic clocked_mode;
  logic master;
  logic rx_req;
  logic master_tx;
  logic nine_bit;

  assign port_on      = receive_control_reg[ssm_pkg::RXC_SERIAL_PORT_ENABLE];
  assign clocked_mode = transmit_control_reg[ssm_pkg::TXC_CLOCKED_MODE];
  assign master       = port_on && clocked_mode &&
                        transmit_control_reg[ssm_pkg::TXC_CLOCK_SOURCE_MASTER];
  assign rx_req       = receive_control_reg[ssm_pkg::RXC_SINGLE_RECEIVE] ||
                        receive_control_reg[ssm_pkg::RXC_CONTINUOUS_RECEIVE];
  assign master_tx    = master && !rx_req &&
                        transmit_control_reg[ssm_pkg::TXC_TRANSMIT_ENABLE];
  assign nine_bit     = transmit_control_reg[ssm_pkg::TXC_NINE_BIT_SELECT];

  // ************************************************************
  // Pins synchronised (sampled only for future receive use)
  // ************************************************************
  logic [1:0] clk_pin_sync;
  logic [1:0] dat_pin_sync;

  // Two flops before any logic may read a pin
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      clk_pin_sync <= 2'b00;
    end else begin
      clk_pin_sync <= {clk_pin_sync[0], CLOCK_PIN_IN};
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      dat_pin_sync <= 2'b00;
    end else begin
      dat_pin_sync <= {dat_pin_sync[0], DATA_PIN_IN};
    end
  end

  // ************************************************************
  // Shift engine
  // ************************************************************
  ssm_pkg::ssm_state_t state;
  ssm_pkg::ssm_state_t next_state;
  logic tick;
  logic load;
  logic shift;
  logic sh_busy;
  logic sh_last;
  logic sh_bit;
  logic [3:0] nbits;
  logic flush;
  logic baud_run;

  assign nbits = nine_bit ? 4'(ssm_pkg::DATA_BITS + 1) : 4'(ssm_pkg::DATA_BITS);
  // load only when shift register is empty and not clocking
  assign load  = master_tx && hold_full && (state == ssm_pkg::SSM_IDLE) && !sh_busy;
  // Advance to the next bit on each leading edge after the first
  assign shift = tick && (state == ssm_pkg::SSM_TRAIL);
  // Baud counter runs only while a character is on the line
  assign baud_run = (state != ssm_pkg::SSM_IDLE);
  // Mode dropped mid-character: empty the shift register so later loads are not blocked
  assign flush = baud_run && !master_tx;

  ssm_baud_gen #(
    .DIV_W (DIV_W)
  ) u_baud (
    .clk_in     (CLK_IN),
    .rst_in     (SYS_RST_IN),
    .run_in     (baud_run),
    .divisor_in (baud_divisor),
    .tick_out   (tick)
  );

  ssm_tx_shift #(
    .WIDTH (9)
  ) u_shift (
    .clk_in   (CLK_IN),
    .rst_in   (SYS_RST_IN || flush),
    .load_in  (load),
    .data_in  (transmit_holding_reg),
    .nbits_in (nbits),
    .shift_in (shift),
    .bit_out  (sh_bit),
    .busy_out (sh_busy),
    .last_out (sh_last)
  );

  // ************************************************************
  // Bit sequencer
  // ************************************************************

  always_comb begin
    next_state = state;
    unique case (state)
      ssm_pkg::SSM_IDLE: begin
        if (load) begin
          next_state = ssm_pkg::SSM_LEAD;
        end
      end
      // Clock low half; data settles
      ssm_pkg::SSM_LEAD: begin
        if (!master_tx) begin
          next_state = ssm_pkg::SSM_IDLE;
        end else if (tick) begin
          next_state = ssm_pkg::SSM_TRAIL;
        end
      end
      // Clock high half; slave samples
      ssm_pkg::SSM_TRAIL: begin
        if (!master_tx) begin
          next_state = ssm_pkg::SSM_IDLE;
        end else if (tick) begin
          next_state = sh_last ? ssm_pkg::SSM_IDLE : ssm_pkg::SSM_LEAD;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      state <= ssm_pkg::SSM_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // Pin drive
  // ************************************************************
  // Shift clock high only in the trailing half of a bit
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      CLOCK_PIN_OUT <= ssm_pkg::SHIFT_CLK_IDLE;
    end else begin
      CLOCK_PIN_OUT <= (next_state == ssm_pkg::SSM_TRAIL) ^ ssm_pkg::SHIFT_CLK_IDLE;
    end
  end

  // Clock driver on in any master mode
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      CLOCK_PIN_OE_OUT <= 1'b0;
    end else begin
      CLOCK_PIN_OE_OUT <= master;
    end
  end

  // Data bit follows the shift register one clock later
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      DATA_PIN_OUT <= 1'b0;
    end else begin
      DATA_PIN_OUT <= sh_bit;
    end
  end

  // Data driver on only in master transmit
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      DATA_PIN_OE_OUT <= 1'b0;
    end else begin
      DATA_PIN_OE_OUT <= master_tx;
    end
  end

  // ************************************************************
  // Register writes
  // ************************************************************
  // Read-only shift-empty bit is masked off
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      transmit_control_reg <= ssm_pkg::TXC_RESET;
    end else if (wr_tx_ctrl) begin
      transmit_control_reg <= PWDATA_IN[7:0] & ssm_pkg::TXC_WRITE_MASK;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      receive_control_reg <= ssm_pkg::RXC_RESET;
    end else if (wr_rx_ctrl) begin
      receive_control_reg <= PWDATA_IN[7:0] & ssm_pkg::RXC_WRITE_MASK;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      baud_divisor <= ssm_pkg::DIV_RESET;
    end else if (wr_baud) begin
      baud_divisor <= PWDATA_IN[DIV_W-1:0];
    end
  end

  // Ninth bit is taken from control at write time
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      transmit_holding_reg <= 9'h000;
    end else if (wr_hold) begin
      transmit_holding_reg <= {transmit_control_reg[ssm_pkg::TXC_NINTH_BIT],
                               PWDATA_IN[7:0]};
    end
  end

  // A write in the load cycle keeps the flag set
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      hold_full <= 1'b0;
    end else if (wr_hold) begin
      hold_full <= 1'b1;
    end else if (load) begin
      hold_full <= 1'b0;
    end
  end

  // ************************************************************
  // Register reads
  // ************************************************************
  logic [7:0]  txc_view;
  logic [31:0] next_prdata;

  always_comb begin
    txc_view = transmit_control_reg;
    txc_view[ssm_pkg::TXC_SHIFT_EMPTY] = !sh_busy && (state == ssm_pkg::SSM_IDLE);
  end

  // Last read data stays outside a read setup
  always_comb begin
    next_prdata = PRDATA_OUT;
    if (apb_read) begin
      unique case (PADDR_IN)
        ssm_pkg::ADDR_TX_CTRL:  next_prdata = {24'h00_0000, txc_view};
        ssm_pkg::ADDR_RX_CTRL:  next_prdata = {24'h00_0000, receive_control_reg};
        ssm_pkg::ADDR_BAUD_DIV: next_prdata = {{(32-DIV_W){1'b0}}, baud_divisor};
        // Holding register reads zero; shift register has no address
        ssm_pkg::ADDR_TX_HOLD:  next_prdata = 32'h0000_0000;
        ssm_pkg::ADDR_STATUS:   next_prdata = {29'h0000_0000, master_tx,
                                               (state != ssm_pkg::SSM_IDLE), hold_full};
        default:                next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else begin
      PRDATA_OUT <= next_prdata;
    end
  end

endmodule : ssm_sync_master_tx

// File: ssm_checker.sv
// Checker of pin and bus behaviour for the sync serial master
`timescale 1ns/1ps
module ssm_checker #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic             CLK_IN,
  input wire logic             SYS_RST_IN,
  // APB
  input wire logic             PSEL_IN,
  input wire logic             PENABLE_IN,
  input wire logic             PWRITE_IN,
  input wire logic [7:0]       PADDR_IN,
  input wire logic [31:0]      PWDATA_IN,
  input wire logic             PSLVERR_OUT,
  // Pins
  input wire logic             CLOCK_PIN_OUT,
  input wire logic             CLOCK_PIN_OE_OUT,
  input wire logic             DATA_PIN_OUT,
  input wire logic             DATA_PIN_OE_OUT
);
  localparam int START_MAX = 800;
  logic [7:0]       tx_ctrl;
  logic [7:0]       rx_ctrl;
  logic [DIV_W-1:0] div;
  logic [9:0]       hi_cnt;
  logic             wr;
  logic             hold_wr;
  logic             cfg_master;
  logic             rx_on;
  logic             cfg_tx;
  assign wr         = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign hold_wr    = wr & (PADDR_IN == ssm_pkg::ADDR_TX_HOLD);
  assign cfg_master = rx_ctrl[7] & tx_ctrl[4] & tx_ctrl[7];
  assign rx_on      = rx_ctrl[5] | rx_ctrl[4];
  assign cfg_tx     = cfg_master & tx_ctrl[5] & !rx_on;
  // Shadow of the mode registers
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      tx_ctrl <= 8'h00;
      rx_ctrl <= 8'h00;
      div     <= '0;
    end else if (wr) begin
      if (PADDR_IN == ssm_pkg::ADDR_TX_CTRL) tx_ctrl <= PWDATA_IN[7:0];
      if (PADDR_IN == ssm_pkg::ADDR_RX_CTRL) rx_ctrl <= PWDATA_IN[7:0];
      if (PADDR_IN == ssm_pkg::ADDR_BAUD_DIV) div <= PWDATA_IN[DIV_W-1:0];
    end
  end
  // Length of the current high half of the shift clock
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN || !CLOCK_PIN_OUT) begin
      hi_cnt <= 10'h000;
    end else begin
      hi_cnt <= hi_cnt + 10'h001;
    end
  end
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  sequence s_tx_held;
    cfg_tx [*3];
  endsequence
  sequence s_rx_held;
    (cfg_master && rx_on) [*3];
  endsequence
  a_clk_oe_mode: assert property ($stable(cfg_master) [*3] |-> CLOCK_PIN_OE_OUT == cfg_master)
    else $error("clock pin enable does not follow master mode");
  a_tx_drives: assert property (s_tx_held |-> DATA_PIN_OE_OUT && CLOCK_PIN_OE_OUT)
    else $error("pin drivers off in master transmit");
  a_rx_no_drive: assert property (s_rx_held |-> !DATA_PIN_OE_OUT)
    else $error("data pin driven while receive enabled");
  a_clk_needs_oe: assert property (CLOCK_PIN_OUT |-> CLOCK_PIN_OE_OUT)
    else $error("shift clock high with driver off");
  a_idle_clk_low: assert property ((!cfg_master) [*4] |-> !CLOCK_PIN_OUT)
    else $error("shift clock active outside master mode");
  a_data_hold: assert property (CLOCK_PIN_OUT && $past(CLOCK_PIN_OUT) |-> $stable(DATA_PIN_OUT))
    else $error("data changed while shift clock high");
  a_high_half: assert property (
    $fell(CLOCK_PIN_OUT) && cfg_tx |-> int'(hi_cnt) == 2 * (int'(div) + 1))
    else $error("shift clock high half has wrong length");
  a_start_write: assert property (
    hold_wr && cfg_tx && int'(div) < 16 |-> ##[1:START_MAX] $rose(CLOCK_PIN_OUT))
    else $error("no shift clock after holding write");
  a_unmapped_err: assert property (
    PSEL_IN && PENABLE_IN && PADDR_IN > ssm_pkg::ADDR_STATUS |-> PSLVERR_OUT)
    else $error("no error on unmapped address");
endmodule : ssm_checker

bind ssm_sync_master_tx ssm_checker #(.DIV_W(DIV_W)) chk (
  .CLK_IN, .SYS_RST_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN,
  .PSLVERR_OUT, .CLOCK_PIN_OUT, .CLOCK_PIN_OE_OUT, .DATA_PIN_OUT, .DATA_PIN_OE_OUT
);

// File: ssm_slave_model.sv
// Behavioural slave that shifts in the master's characters
`timescale 1ns/1ps
module ssm_slave_model (
  // Link
  input wire logic       rst_in,
  input wire logic       clk_line_in,
  input wire logic       data_line_in,
  input wire logic [3:0] nbits_in,
  // Received
  output logic [8:0]     char_out,
  output int             nchar_out,
  output int             nedge_out
);
  int         cnt;
  logic [8:0] acc;
  // Samples on the trailing edge and never drives the data line
  always @(posedge clk_line_in or posedge rst_in) begin
    if (rst_in) begin
      cnt       = 0;
      acc       = 9'h000;
      char_out  = 9'h000;
      nchar_out = 0;
      nedge_out = 0;
    end else begin
      acc[cnt]  = data_line_in;
      cnt       = cnt + 1;
      nedge_out = nedge_out + 1;
      if (cnt == int'(nbits_in)) begin
        char_out  = acc;
        nchar_out = nchar_out + 1;
        cnt       = 0;
        acc       = 9'h000;
      end
    end
  end
endmodule : ssm_slave_model

// File: tb.sv
// Self-checking testbench for the sync serial master transmit path
`timescale 1ns/1ps
module tb;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ck_out;
  logic        ck_oe;
  logic        dt_out;
  logic        dt_oe;
  logic        ck_line;
  logic        dt_line;
  logic        slv_rst;
  logic [3:0]  nbits;
  logic [8:0]  rx_char;
  int          nchar;
  int          nedge;
  int          bad_count;
  int          num_checks;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  mtx [6] = '{8'hb0, 8'hb0, 8'ha0, 8'h30, 8'hb0, 8'hb0};
  logic [7:0]  mrx [6] = '{8'ha0, 8'h90, 8'h80, 8'h80, 8'h00, 8'h80};
  // Released lines: clock pulled low, data pulled high
  assign ck_line = ck_oe ? ck_out : 1'b0;
  assign dt_line = dt_oe ? dt_out : 1'b1;
  always #2.5 clk = ~clk;
  ssm_sync_master_tx dut (
    .CLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .CLOCK_PIN_IN(ck_line), .CLOCK_PIN_OUT(ck_out),
    .CLOCK_PIN_OE_OUT(ck_oe), .DATA_PIN_IN(dt_line), .DATA_PIN_OUT(dt_out),
    .DATA_PIN_OE_OUT(dt_oe));
  ssm_slave_model slv (
    .rst_in(slv_rst), .clk_line_in(ck_line), .data_line_in(dt_line), .nbits_in(nbits),
    .char_out(rx_char), .nchar_out(nchar), .nedge_out(nedge));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd   = prdata;
    err  = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask : rchk
  task automatic wait_chars(input int n);
    while (nchar < n) begin
      @(posedge clk);
    end
  endtask : wait_chars
  task automatic slave_reset(input logic [3:0] bits);
    slv_rst = 1'b1;
    nbits   = bits;
    #1 slv_rst = 1'b0;
  endtask : slave_reset
  initial begin
    #50000;
    bad_count++;
    complete_run();
  end
  initial begin
    clk = 0; rst = 1; psel = 0; pen = 0; pwr = 0; paddr = 8'h00; pwdata = 32'h0;
    bad_count = 0; num_checks = 0;
    repeat (3) @(posedge clk);
    slave_reset(4'h8);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rchk("rx_ctrl", ssm_pkg::ADDR_RX_CTRL, 32'h0);
    check("mapped err", 32'(err), 32'h0);
    rchk("baud_div", ssm_pkg::ADDR_BAUD_DIV, 32'h0);
    rchk("status", ssm_pkg::ADDR_STATUS, 32'h0);
    rchk("tx_ctrl", ssm_pkg::ADDR_TX_CTRL, 32'h2);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped err", 32'(err), 32'h1);
    $display("test reset done");
    apb(1'b1, ssm_pkg::ADDR_BAUD_DIV, 32'h1);
    apb(1'b1, ssm_pkg::ADDR_RX_CTRL, 32'h80);
    apb(1'b1, ssm_pkg::ADDR_TX_CTRL, 32'hb0);
    rchk("status mode", ssm_pkg::ADDR_STATUS, 32'h4);
    apb(1'b1, ssm_pkg::ADDR_TX_HOLD, 32'ha5);
    apb(1'b1, ssm_pkg::ADDR_TX_HOLD, 32'h3c);
    rchk("hold read", ssm_pkg::ADDR_TX_HOLD, 32'h0);
    wait_chars(1);
    check("char one", 32'(rx_char), 32'ha5);
    wait_chars(2);
    check("char two", 32'(rx_char), 32'h3c);
    repeat (100) @(posedge clk);
    check("clock edges", 32'(nedge), 32'd16);
    check("clock idle", 32'(ck_out), 32'h0);
    rchk("shift empty", ssm_pkg::ADDR_TX_CTRL, 32'hb2);
    $display("test back to back done");
    slave_reset(4'h9);
    apb(1'b1, ssm_pkg::ADDR_TX_CTRL, 32'hf1);
    apb(1'b1, ssm_pkg::ADDR_TX_HOLD, 32'h5a);
    wait_chars(1);
    check("nine bit char", 32'(rx_char), 32'h15a);
    $display("test nine bit done");
    slave_reset(4'h8);
    apb(1'b1, ssm_pkg::ADDR_TX_CTRL, 32'hb0);
    apb(1'b1, ssm_pkg::ADDR_TX_HOLD, 32'hff);
    repeat (12) @(posedge clk);
    apb(1'b1, ssm_pkg::ADDR_TX_CTRL, 32'h90);
    repeat (10) @(posedge clk);
    check("abort clock", 32'(ck_out), 32'h0);
    check("abort data oe", 32'(dt_oe), 32'h0);
    rchk("abort empty", ssm_pkg::ADDR_TX_CTRL, 32'h92);
    $display("test abort done");
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, ssm_pkg::ADDR_RX_CTRL, 32'(mrx[i]));
      apb(1'b1, ssm_pkg::ADDR_TX_CTRL, 32'(mtx[i]));
      repeat (4) @(posedge clk);
      check("clock oe", 32'(ck_oe), 32'(mrx[i][7] & mtx[i][4] & mtx[i][7]));
      check("data oe", 32'(dt_oe), 32'(mrx[i][7] & mtx[i][4] & mtx[i][7] & mtx[i][5]
        & !(mrx[i][5] | mrx[i][4])));
    end
    $display("test modes done");
    complete_run();
  end
endmodule : tb
